// ==== logic/ecc_pkg.sv ====
// constants, types and helpers for the electronic cam clutch block
// assumes one 25 MHz clock and an Avalon-MM slave port with waitrequest
package ecc_pkg;

	// *****************************************
	// timing and sizes
	// *****************************************
	localparam int unsigned ECC_CLK_HZ = 25_000_000;
	localparam int unsigned ECC_TICK_MS = 1;
	localparam int unsigned ECC_TICK_CYC = ECC_CLK_HZ / 1000 * ECC_TICK_MS;
	localparam int unsigned ECC_DEPTH = 800;
	localparam logic [9:0] ECC_LAST_IDX = 10'h31F;

	// *****************************************
	// address map (byte addresses)
	// *****************************************
	localparam logic [1:0] ECC_RGN_REG = 2'h0;
	localparam logic [1:0] ECC_RGN_ARR = 2'h1;
	localparam logic [1:0] ECC_RGN_NV = 2'h2;
	localparam logic [11:0] ECC_OFS_CTRL = 12'h000;
	localparam logic [11:0] ECC_OFS_DIS = 12'h004;
	localparam logic [11:0] ECC_OFS_LEAD = 12'h008;
	localparam logic [11:0] ECC_OFS_SKIP = 12'h00C;
	localparam logic [11:0] ECC_OFS_SCALE = 12'h010;
	localparam logic [11:0] ECC_OFS_BASE = 12'h014;
	localparam logic [11:0] ECC_OFS_NPTS = 12'h018;
	localparam logic [11:0] ECC_OFS_PPP = 12'h01C;
	localparam logic [11:0] ECC_OFS_FORCE = 12'h020;
	localparam logic [11:0] ECC_OFS_STAT = 12'h024;
	localparam logic [11:0] ECC_OFS_SLAVE = 12'h028;
	localparam logic [11:0] ECC_OFS_TRAVEL = 12'h02C;

	// *****************************************
	// fields and values
	// *****************************************
	localparam int unsigned ECC_ACT_EN = 0;
	localparam int unsigned ECC_ACT_HOLD = 1;
	localparam int unsigned ECC_ACT_SCALE = 2;
	localparam int unsigned ECC_NIB_SRC = 1;
	localparam int unsigned ECC_NIB_ENG = 2;
	localparam int unsigned ECC_NIB_DIS = 3;
	localparam int unsigned ECC_PROC_LSB = 16;
	localparam logic [7:0] ECC_PROC_MAX = 8'h3F;
	localparam logic [3:0] ECC_SRC_AUX = 4'h1;
	localparam logic [3:0] ECC_SRC_CMD = 4'h2;
	localparam logic [3:0] ECC_SRC_TIME = 4'h4;
	localparam logic [3:0] ECC_ENG_NOW = 4'h0;
	localparam logic [3:0] ECC_DIS_DI = 4'h1;
	localparam logic [3:0] ECC_DIS_ONCE = 4'h2;
	localparam logic [3:0] ECC_DIS_RESUME = 4'h4;
	localparam logic [3:0] ECC_DIS_COAST = 4'h6;
	localparam int unsigned ECC_DIS_OFF = 3;
	// forcing codes 30 then 35
	localparam logic [7:0] ECC_FORCE_ARM = 8'h1E;
	localparam logic [7:0] ECC_FORCE_GO = 8'h23;
	localparam int unsigned ECC_SCALE_SHIFT = 16;
	localparam logic [31:0] ECC_SCALE_RST = 32'h0001_0000;
	localparam logic [31:0] ECC_ZERO = 32'h0000_0000;
	localparam logic [9:0] ECC_ONE10 = 10'h001;
	localparam logic [15:0] ECC_ONE16 = 16'h0001;

	// *****************************************
	// types
	// *****************************************
	typedef enum logic [2:0] {
		ECC_IDLE, ECC_WAIT, ECC_LEAD, ECC_ENG, ECC_DRAIN, ECC_STOP
	} ecc_state_t;

	typedef struct packed {
		logic [13:0] address;
		logic [3:0] byteenable;
		logic read;
		logic write;
		logic [31:0] writedata;
	} ecc_avm_req_t;

	typedef struct packed {
		logic aux_step;
		logic aux_dir;
		logic cmd_step;
		logic cmd_dir;
	} ecc_master_t;

	typedef struct packed {
		logic pr_mode;
		logic servo_on;
		logic alarm;
		logic cam_engage_input;
	} ecc_drive_t;

	typedef struct packed {
		ecc_state_t st;
		logic [31:0] ctrl;
		logic [31:0] dis;
		logic [31:0] lead;
		logic [31:0] skip;
		logic [31:0] scale;
		logic [31:0] scale_act;
		logic [9:0] base;
		logic [9:0] npts;
		logic [15:0] ppp;
		logic [7:0] force_prev;
		logic copying;
		logic [9:0] cp_idx;
		logic [31:0] travel;
		logic [31:0] cnt;
		logic [31:0] lead_use;
		logic [9:0] idx;
		logic [15:0] sub;
		logic [31:0] slave;
		logic di_prev;
		logic [31:0] tick;
		logic engaged;
		logic proc_go;
		logic [7:0] proc_num;
		logic waitrequest;
		logic [31:0] rdata;
	} ecc_regs_t;

	function automatic logic [3:0] ecc_nib(input logic [31:0] w,
		input int unsigned k);
		return w[k*4 +: 4];
	endfunction

endpackage

// ==== logic/ecc_cam_clutch.sv ====
// electronic cam with clutch, lead count, disengage modes and data array
// assumes master pulse strobes and drive status synchronous to clk_sys
`timescale 1ns/100ps

module ecc_cam_clutch #(
	parameter int unsigned TICK_CYCLES = ecc_pkg::ECC_TICK_CYC
) (
	// clock and reset
	input logic clk_sys,
	input logic rst_n,
	// register bus
	input ecc_pkg::ecc_avm_req_t avm_req,
	output logic avm_waitrequest,
	output logic [31:0] avm_readdata,
	// master pulses and drive status
	input ecc_pkg::ecc_master_t master_in,
	input ecc_pkg::ecc_drive_t drive_in,
	// cam results
	output logic [31:0] slave_pos,
	output logic clutch_engaged,
	output logic cam_enabled,
	output logic procedure_start,
	output logic [7:0] procedure_number,
	output logic nv_copy_busy
);

	// *****************************************
	// state and storage
	// *****************************************
	ecc_pkg::ecc_regs_t s, next_s;
	logic [31:0] mem [0:ecc_pkg::ECC_DEPTH-1];
	logic [31:0] nvm [0:ecc_pkg::ECC_DEPTH-1];
	logic mem_we, nv_we, mv, dn, en, servo_ok, di_rise, di_fall;
	logic tick_hit, reach, exceed, go_stop, adv, wrap, locked, acc;
	logic [3:0] unib;
	logic [9:0] mem_wa, aidx, tidx;
	logic [31:0] rv, wd, tnext, tbl;
	logic signed [63:0] prod;

	function automatic logic ecc_in_range(input logic [9:0] i);
		return i <= ecc_pkg::ECC_LAST_IDX;
	endfunction

	function automatic logic [31:0] ecc_merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// *****************************************
	// next state
	// *****************************************
	always_comb begin
		next_s = s;
		next_s.proc_go = 1'b0;
		next_s.waitrequest = 1'b1;
		mem_we = 1'b0;
		nv_we = 1'b0;
		mem_wa = avm_req.address[11:2];
		aidx = avm_req.address[11:2];
		unib = ecc_pkg::ecc_nib(s.ctrl, ecc_pkg::ECC_NIB_DIS);
		en = s.ctrl[ecc_pkg::ECC_ACT_EN] && drive_in.pr_mode;
		servo_ok = drive_in.servo_on && !drive_in.alarm;
		di_rise = drive_in.cam_engage_input && !s.di_prev;
		di_fall = !drive_in.cam_engage_input && s.di_prev;
		next_s.di_prev = drive_in.cam_engage_input;
		tick_hit = s.tick == 32'(TICK_CYCLES - 1);
		next_s.tick = tick_hit ? ecc_pkg::ECC_ZERO : s.tick + 32'h0000_0001;
		case (ecc_pkg::ecc_nib(s.ctrl, ecc_pkg::ECC_NIB_SRC))
			ecc_pkg::ECC_SRC_AUX: begin
				mv = master_in.aux_step;
				dn = master_in.aux_dir;
			end
			ecc_pkg::ECC_SRC_CMD: begin
				mv = master_in.cmd_step;
				dn = master_in.cmd_dir;
			end
			ecc_pkg::ECC_SRC_TIME: begin
				mv = tick_hit;
				dn = 1'b0;
			end
			default: begin
				mv = 1'b0;
				dn = 1'b0;
			end
		endcase
		// signed travel since engagement
		tnext = s.travel;
		if (mv && servo_ok) begin
			tnext = dn ? s.travel - 32'h0000_0001 : s.travel + 32'h0000_0001;
		end
		reach = $signed(s.dis) >= 0 ? $signed(tnext) >= $signed(s.dis)
			: $signed(tnext) <= $signed(s.dis);
		exceed = $signed(s.dis) >= 0 ? $signed(tnext) > $signed(s.dis)
			: $signed(tnext) < $signed(s.dis);
		// profile point stepping, no rate limiting on the slave
		adv = (s.st == ecc_pkg::ECC_ENG || s.st == ecc_pkg::ECC_DRAIN)
			&& mv && servo_ok;
		wrap = 1'b0;
		if (adv) begin
			next_s.travel = tnext;
			if (dn) begin
				wrap = s.sub == 16'h0000;
				next_s.sub = wrap ? s.ppp - ecc_pkg::ECC_ONE16
					: s.sub - ecc_pkg::ECC_ONE16;
				if (wrap) begin
					next_s.idx = s.idx == 10'h000 ? s.npts - ecc_pkg::ECC_ONE10
						: s.idx - ecc_pkg::ECC_ONE10;
				end
			end else begin
				wrap = s.sub == s.ppp - ecc_pkg::ECC_ONE16;
				next_s.sub = wrap ? 16'h0000 : s.sub + ecc_pkg::ECC_ONE16;
				if (wrap) begin
					next_s.idx = s.idx == s.npts - ecc_pkg::ECC_ONE10 ? 10'h000
						: s.idx + ecc_pkg::ECC_ONE10;
				end
			end
		end
		// cam table lookup scaled in Q16
		tidx = s.base + s.idx;
		tbl = ecc_in_range(tidx) ? mem[tidx] : ecc_pkg::ECC_ZERO;
		prod = $signed(tbl) * $signed(s.scale_act);
		if (s.st == ecc_pkg::ECC_ENG || s.st == ecc_pkg::ECC_DRAIN) begin
			next_s.slave = prod[ecc_pkg::ECC_SCALE_SHIFT +: 32];
			if (s.ctrl[ecc_pkg::ECC_ACT_SCALE]) begin
				next_s.scale_act = s.scale;
			end
		end
		go_stop = 1'b0;
		case (s.st)
			ecc_pkg::ECC_IDLE: begin
				if (en) begin
					next_s.st = ecc_pkg::ECC_WAIT;
					next_s.lead_use = s.lead;
				end
			end
			ecc_pkg::ECC_WAIT: begin
				if (ecc_pkg::ecc_nib(s.ctrl, ecc_pkg::ECC_NIB_ENG)
					== ecc_pkg::ECC_ENG_NOW || di_rise) begin
					next_s.st = ecc_pkg::ECC_LEAD;
					next_s.cnt = ecc_pkg::ECC_ZERO;
				end
			end
			ecc_pkg::ECC_LEAD: begin
				if (mv) begin
					next_s.cnt = s.cnt + 32'h0000_0001;
				end
				if (s.cnt >= s.lead_use) begin
					next_s.st = ecc_pkg::ECC_ENG;
					next_s.engaged = 1'b1;
					next_s.travel = ecc_pkg::ECC_ZERO;
					next_s.idx = 10'h000;
					next_s.sub = 16'h0000;
					next_s.scale_act = s.scale;
				end
			end
			ecc_pkg::ECC_ENG: begin
				if (!servo_ok && !s.ctrl[ecc_pkg::ECC_ACT_HOLD]) begin
					go_stop = 1'b1;
				end else if (unib[2:0] == ecc_pkg::ECC_DIS_DI[2:0]) begin
					go_stop = di_fall;
				end else if (unib[2:0] == ecc_pkg::ECC_DIS_ONCE[2:0] && reach)
					begin
					go_stop = 1'b1;
				end else if (unib[2:0] == ecc_pkg::ECC_DIS_COAST[2:0] && reach)
					begin
					next_s.st = ecc_pkg::ECC_DRAIN;
				end else if (unib[2:0] == ecc_pkg::ECC_DIS_RESUME[2:0]
					&& exceed) begin
					next_s.st = ecc_pkg::ECC_LEAD;
					next_s.engaged = 1'b0;
					next_s.cnt = ecc_pkg::ECC_ZERO;
					next_s.lead_use = s.skip;
				end
				// auto procedure on distance-based disengage
				if (reach && (unib[2:0] == ecc_pkg::ECC_DIS_ONCE[2:0]
					|| unib[2:0] == ecc_pkg::ECC_DIS_COAST[2:0])
					|| exceed && unib[2:0] == ecc_pkg::ECC_DIS_RESUME[2:0]) begin
					if (servo_ok || s.ctrl[ecc_pkg::ECC_ACT_HOLD]) begin
						next_s.proc_num = s.ctrl[ecc_pkg::ECC_PROC_LSB +: 8];
						next_s.proc_go = s.ctrl[ecc_pkg::ECC_PROC_LSB +: 8] != 8'h00
							&& s.ctrl[ecc_pkg::ECC_PROC_LSB +: 8]
							<= ecc_pkg::ECC_PROC_MAX;
					end
				end
			end
			ecc_pkg::ECC_DRAIN: begin
				// keep present speed up to the next profile point
				go_stop = wrap || !servo_ok;
			end
			ecc_pkg::ECC_STOP: begin
			end
			default: begin
				next_s.st = ecc_pkg::ECC_IDLE;
			end
		endcase
		if (go_stop) begin
			next_s.st = ecc_pkg::ECC_STOP;
			next_s.engaged = 1'b0;
			if (unib[ecc_pkg::ECC_DIS_OFF]
				&& (unib[2:0] == ecc_pkg::ECC_DIS_DI[2:0]
				|| unib[2:0] == ecc_pkg::ECC_DIS_ONCE[2:0]
				|| unib[2:0] == ecc_pkg::ECC_DIS_COAST[2:0])) begin
				next_s.ctrl[ecc_pkg::ECC_ACT_EN] = 1'b0;
			end
		end
		if (!en) begin
			next_s.st = ecc_pkg::ECC_IDLE;
			next_s.engaged = 1'b0;
		end
		// *****************************************
		// register bus
		// *****************************************
		case (avm_req.address[11:0])
			ecc_pkg::ECC_OFS_CTRL: rv = s.ctrl;
			ecc_pkg::ECC_OFS_DIS: rv = s.dis;
			ecc_pkg::ECC_OFS_LEAD: rv = s.lead;
			ecc_pkg::ECC_OFS_SKIP: rv = s.skip;
			ecc_pkg::ECC_OFS_SCALE: rv = s.scale;
			ecc_pkg::ECC_OFS_BASE: rv = {22'h00_0000, s.base};
			ecc_pkg::ECC_OFS_NPTS: rv = {22'h00_0000, s.npts};
			ecc_pkg::ECC_OFS_PPP: rv = {16'h0000, s.ppp};
			ecc_pkg::ECC_OFS_FORCE: rv = {24'h00_0000, s.force_prev};
			ecc_pkg::ECC_OFS_STAT: rv = {27'h000_0000, s.st, s.copying,
				s.engaged};
			ecc_pkg::ECC_OFS_SLAVE: rv = s.slave;
			ecc_pkg::ECC_OFS_TRAVEL: rv = s.travel;
			default: rv = ecc_pkg::ECC_ZERO;
		endcase
		case (avm_req.address[13:12])
			ecc_pkg::ECC_RGN_REG: begin
			end
			ecc_pkg::ECC_RGN_ARR: rv = ecc_in_range(aidx) ? mem[aidx]
				: ecc_pkg::ECC_ZERO;
			ecc_pkg::ECC_RGN_NV: rv = ecc_in_range(aidx) ? nvm[aidx]
				: ecc_pkg::ECC_ZERO;
			default: rv = ecc_pkg::ECC_ZERO;
		endcase
		wd = ecc_merge(rv, avm_req.writedata, avm_req.byteenable);
		acc = (avm_req.read || avm_req.write) && s.waitrequest;
		locked = s.ctrl[ecc_pkg::ECC_ACT_EN];
		if (acc) begin
			next_s.waitrequest = 1'b0;
			next_s.rdata = avm_req.read ? rv : ecc_pkg::ECC_ZERO;
		end
		if (acc && avm_req.write) begin
			if (avm_req.address[13:12] == ecc_pkg::ECC_RGN_ARR) begin
				mem_we = ecc_in_range(aidx);
			end else if (avm_req.address[13:12] == ecc_pkg::ECC_RGN_REG) begin
				case (avm_req.address[11:0])
					ecc_pkg::ECC_OFS_CTRL: next_s.ctrl = wd;
					ecc_pkg::ECC_OFS_SCALE: next_s.scale = wd;
					ecc_pkg::ECC_OFS_DIS: if (!locked) next_s.dis = wd;
					ecc_pkg::ECC_OFS_LEAD: if (!locked) next_s.lead = wd;
					ecc_pkg::ECC_OFS_SKIP: if (!locked) next_s.skip = wd;
					ecc_pkg::ECC_OFS_BASE: if (!locked) next_s.base = wd[9:0];
					ecc_pkg::ECC_OFS_NPTS: if (!locked && wd[9:0] != 10'h000)
						next_s.npts = wd[9:0];
					ecc_pkg::ECC_OFS_PPP: if (!locked && wd[15:0] != 16'h0000)
						next_s.ppp = wd[15:0];
					ecc_pkg::ECC_OFS_FORCE: begin
						next_s.force_prev = wd[7:0];
						if (wd[7:0] == ecc_pkg::ECC_FORCE_GO
							&& s.force_prev == ecc_pkg::ECC_FORCE_ARM) begin
							next_s.copying = 1'b1;
							next_s.cp_idx = 10'h000;
						end
					end
					default: begin
					end
				endcase
			end
		end
		// copy one word per cycle into the retained store
		if (s.copying) begin
			nv_we = 1'b1;
			next_s.cp_idx = s.cp_idx + ecc_pkg::ECC_ONE10;
			if (s.cp_idx == ecc_pkg::ECC_LAST_IDX) begin
				next_s.copying = 1'b0;
			end
		end
	end

	// *****************************************
	// registers
	// *****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= ecc_pkg::ECC_IDLE;
			s.scale <= ecc_pkg::ECC_SCALE_RST;
			s.scale_act <= ecc_pkg::ECC_SCALE_RST;
			s.npts <= ecc_pkg::ECC_ONE10;
			s.ppp <= ecc_pkg::ECC_ONE16;
			s.waitrequest <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// no reset on the arrays: contents are undefined after power-up
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem[mem_wa] <= wd;
		end
		if (nv_we) begin
			nvm[s.cp_idx] <= mem[s.cp_idx];
		end
	end

	assign avm_waitrequest = s.waitrequest;
	assign avm_readdata = s.rdata;
	assign slave_pos = s.slave;
	assign clutch_engaged = s.engaged;
	assign cam_enabled = s.ctrl[ecc_pkg::ECC_ACT_EN];
	assign procedure_start = s.proc_go;
	assign procedure_number = s.proc_num;
	assign nv_copy_busy = s.copying;

	// *****************************************
	// assertions
	// *****************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_locked_param: assert property (acc && avm_req.write && locked
		&& avm_req.address == {ecc_pkg::ECC_RGN_REG, ecc_pkg::ECC_OFS_DIS}
		|=> $stable(s.dis)) else $error("disengage value changed while on");
	a_mode_gate: assert property (!drive_in.pr_mode |=> s.st ==
		ecc_pkg::ECC_IDLE && !s.engaged) else $error("cam ran outside pr mode");
	a_edge_engage: assert property (s.st == ecc_pkg::ECC_WAIT && en
		&& ecc_pkg::ecc_nib(s.ctrl, ecc_pkg::ECC_NIB_ENG) != ecc_pkg::ECC_ENG_NOW
		&& !di_rise |=> s.st == ecc_pkg::ECC_WAIT) else $error("engaged w/o edge");
	a_lead_hold: assert property (s.st == ecc_pkg::ECC_LEAD && en
		&& s.cnt < s.lead_use |=> !s.engaged) else $error("lead count skipped");
	a_proc_start: assert property (s.proc_go |-> s.proc_num != 8'h00
		&& $past(s.st) == ecc_pkg::ECC_ENG) else $error("bad procedure start");
	a_servo_drop: assert property (s.st == ecc_pkg::ECC_ENG && en && !servo_ok
		&& !s.ctrl[ecc_pkg::ECC_ACT_HOLD] |=> !s.engaged ##1 !s.engaged)
		else $error("clutch held on servo off");
	a_auto_off: assert property (s.st == ecc_pkg::ECC_ENG && go_stop
		&& unib == 4'hA |=> !s.ctrl[ecc_pkg::ECC_ACT_EN] && !s.engaged)
		else $error("activation not cleared");
	a_once_stop: assert property (s.st == ecc_pkg::ECC_ENG && en && servo_ok
		&& unib == ecc_pkg::ECC_DIS_ONCE && reach |=> s.st == ecc_pkg::ECC_STOP)
		else $error("no stop at disengage value");
	a_stop_still: assert property (s.st == ecc_pkg::ECC_STOP |=> $stable(s.slave))
		else $error("slave moved while disengaged");
	a_bus_answer: assert property (acc |=> !s.waitrequest ##1 s.waitrequest)
		else $error("bus answer timing wrong");

endmodule // ecc_cam_clutch

// ==== testbench/ecc_master_model.sv ====
// master pulse source model: auxiliary encoder or pulse command input
// assumes the bench calls send() just after a rising edge of clk_sys
`timescale 1ns/100ps

module ecc_master_model (
	// clock
	input wire logic clk_sys,
	// strobes towards the cam block
	output ecc_pkg::ecc_master_t master_in
);
	ecc_pkg::ecc_master_t m;

	assign master_in = m;

	initial begin
		m = '0;
	end

	// one strobe per count, then a quiet cycle
	// dir flips once released so a stale level is never trusted
	task automatic send(input int n, input logic use_cmd, input logic dir);
		repeat (n) begin
			m.aux_step <= !use_cmd;
			m.cmd_step <= use_cmd;
			m.aux_dir <= dir;
			m.cmd_dir <= dir;
			@(posedge clk_sys);
			m.aux_step <= 1'b0;
			m.cmd_step <= 1'b0;
			m.aux_dir <= !dir;
			m.cmd_dir <= !dir;
			@(posedge clk_sys);
		end
	endtask
endmodule // ecc_master_model

// ==== testbench/test_electronic_cam_clutch_control.sv ====
// self-checking bench for the electronic cam clutch block
// assumes the block answers every bus request after one cycle
`timescale 1ns/100ps

module test_electronic_cam_clutch_control;
	// *****************************************
	// signals
	// *****************************************
	localparam logic [13:0] A_CTRL = 14'h0000;
	localparam logic [13:0] A_DIS = 14'h0004;
	localparam logic [13:0] A_SCALE = 14'h0010;
	localparam logic [13:0] A_FORCE = 14'h0020;
	localparam logic [13:0] A_ARR0 = 14'h1000;
	logic clk_sys;
	logic rst_n;
	ecc_pkg::ecc_avm_req_t avm_req;
	logic avm_waitrequest;
	logic [31:0] avm_readdata;
	ecc_pkg::ecc_master_t master_in;
	ecc_pkg::ecc_drive_t drive_in;
	logic [31:0] slave_pos;
	logic clutch_engaged;
	logic cam_enabled;
	logic procedure_start;
	logic [7:0] procedure_number;
	logic nv_copy_busy;
	logic seen_start;
	logic [31:0] rd;
	int err_count;
	int n_tests;

	// short tick keeps the time-base case fast
	ecc_cam_clutch #(.TICK_CYCLES(10)) i_dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.avm_req(avm_req),
		.avm_waitrequest(avm_waitrequest),
		.avm_readdata(avm_readdata),
		.master_in(master_in),
		.drive_in(drive_in),
		.slave_pos(slave_pos),
		.clutch_engaged(clutch_engaged),
		.cam_enabled(cam_enabled),
		.procedure_start(procedure_start),
		.procedure_number(procedure_number),
		.nv_copy_busy(nv_copy_busy)
	);

	ecc_master_model i_src (
		.clk_sys(clk_sys),
		.master_in(master_in)
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = !clk_sys;
	end

	always @(posedge clk_sys) begin
		if (procedure_start === 1'b1) seen_start <= 1'b1;
	end

	// *****************************************
	// tasks
	// *****************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// request held until waitrequest is sampled low
	task bus(input logic wr, input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avm_req.address <= a;
		avm_req.byteenable <= 4'hF;
		avm_req.writedata <= d;
		avm_req.write <= wr;
		avm_req.read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avm_waitrequest !== 1'b0 && n < 64);
		rd = avm_readdata;
		if (n >= 64) err_count++;
		avm_req.write <= 1'b0;
		avm_req.read <= 1'b0;
	endtask

	task wr(input logic [13:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rchk(input logic [13:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task complete_run;
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		err_count++;
		complete_run;
	end

	// *****************************************
	// tests
	// *****************************************
	initial begin
		err_count = 0;
		n_tests = 0;
		seen_start = 1'b0;
		rst_n = 1'b0;
		avm_req = '0;
		drive_in = '0;
		drive_in.servo_on = 1'b1;
		cyc(12);
		rst_n <= 1'b1;
		rchk(A_CTRL, 32'h0000_0000);
		rchk(A_SCALE, 32'h0001_0000);
		rchk(14'h3000, 32'h0000_0000);
		wr(A_ARR0, 32'h0000_0005);
		wr(14'h1C7C, 32'hA5A5_0001);
		rchk(A_ARR0, 32'h0000_0005);
		rchk(14'h1C7C, 32'hA5A5_0001);
		rchk(14'h1C80, 32'h0000_0000);
		// no engagement outside procedure-register mode
		wr(A_CTRL, 32'h0000_0011);
		cyc(6);
		chk(clutch_engaged, 1'b0);
		drive_in.pr_mode <= 1'b1;
		cyc(6);
		chk(clutch_engaged, 1'b1);
		wr(A_DIS, 32'h0000_0007);
		rchk(A_DIS, 32'h0000_0000);
		i_src.send(1, 1'b0, 1'b0);
		cyc(4);
		chk(slave_pos, 32'h0000_0005);
		cyc(20);
		chk(clutch_engaged, 1'b1);
		wr(A_CTRL, 32'h0000_0000);
		cyc(4);
		chk(clutch_engaged, 1'b0);
		// engage and disengage by the engage input
		wr(A_CTRL, 32'h0000_1111);
		cyc(6);
		chk(clutch_engaged, 1'b0);
		drive_in.cam_engage_input <= 1'b1;
		cyc(6);
		chk(clutch_engaged, 1'b1);
		drive_in.cam_engage_input <= 1'b0;
		cyc(4);
		chk(clutch_engaged, 1'b0);
		wr(A_CTRL, 32'h0000_0000);
		// disengage once with auto-disable and procedure 05
		wr(A_DIS, 32'h0000_0003);
		wr(A_CTRL, 32'h0005_A011);
		cyc(6);
		i_src.send(3, 1'b0, 1'b0);
		cyc(4);
		chk(clutch_engaged, 1'b0);
		chk(cam_enabled, 1'b0);
		chk(seen_start, 1'b1);
		chk(procedure_number, 8'h05);
		// negative travel on the pulse command input, procedure 00
		seen_start <= 1'b0;
		wr(A_DIS, 32'hFFFF_FFFE);
		wr(A_CTRL, 32'h0000_2021);
		cyc(6);
		i_src.send(1, 1'b1, 1'b1);
		cyc(4);
		chk(clutch_engaged, 1'b1);
		i_src.send(1, 1'b1, 1'b1);
		cyc(4);
		chk(clutch_engaged, 1'b0);
		chk(seen_start, 1'b0);
		// internal time base drives the travel
		wr(A_CTRL, 32'h0000_0000);
		wr(A_DIS, 32'h0000_0003);
		wr(A_CTRL, 32'h0000_2041);
		cyc(6);
		chk(clutch_engaged, 1'b1);
		cyc(60);
		chk(clutch_engaged, 1'b0);
		wr(A_CTRL, 32'h0000_0000);
		// servo off without the hold bit drops the clutch
		wr(A_CTRL, 32'h0000_0011);
		cyc(6);
		chk(clutch_engaged, 1'b1);
		drive_in.servo_on <= 1'b0;
		cyc(4);
		chk(clutch_engaged, 1'b0);
		drive_in.servo_on <= 1'b1;
		wr(A_CTRL, 32'h0000_0000);
		// forcing sequence copies the array to the retained store
		wr(A_FORCE, 32'h0000_001E);
		wr(A_FORCE, 32'h0000_0023);
		cyc(2);
		chk(nv_copy_busy, 1'b1);
		cyc(820);
		chk(nv_copy_busy, 1'b0);
		rchk(14'h2000, 32'h0000_0005);
		complete_run;
	end
endmodule // test_electronic_cam_clutch_control
